/* blssb_flash_model.sv */
// Behavioural serial flash that answers the boot loader on its flash pins.
`timescale 1ns/1ps
`default_nettype none
module blssb_flash_model (
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso
);
  // ****************************************
  // Storage and frame logs.
  // ****************************************
  logic [7:0] mem [0:8191];
  logic [7:0] got [$];
  logic [7:0] ops [$];
  logic [23:0] addrs [$];
  int lens [$];
  logic [7:0] sh, rd;
  logic [23:0] ptr;
  int nbit;
  initial begin
    o_miso = 1'b0;
    nbit = 0;
    rd = 8'h00;
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5A;
    mem[0] = 8'h00;
    mem[1] = 8'h10;
    mem[2] = 8'h00;
    mem[3] = 8'h00;
    mem[4] = 8'h10;
    mem[5] = 8'h03;
  end
  // ****************************************
  // Mode 0 shifting: sample on rise, launch on fall.
  // ****************************************
  always @(negedge i_sel_n) begin
    nbit = 0;
    got.delete();
  end
  always @(posedge i_sel_n) begin
    if (got.size() > 0) begin
      ops.push_back(got[0]);
      lens.push_back(got.size());
    end
    if (got.size() > 3) addrs.push_back({got[1], got[2], got[3]});
    // A released line must not keep showing the last bit.
    o_miso <= ~o_miso;
  end
  always @(posedge i_sclk) begin
    if (!i_sel_n) begin
      sh = {sh[6:0], i_mosi};
      nbit = nbit + 1;
      if (nbit == 8) begin
        nbit = 0;
        got.push_back(sh);
        if (got.size() == 4) ptr = {got[1], got[2], got[3]};
        if (got.size() >= 4 && got[0] == 8'h03) begin
          rd = mem[ptr[12:0]];
          ptr = ptr + 24'h000001;
        end
      end
    end
  end
  always @(negedge i_sclk) begin
    if (!i_sel_n) o_miso <= rd[3'(7 - nbit)];
  end
endmodule
`default_nettype wire

/* blssb_pkg.sv */
// Package of constants and types for the boot loader serial SPI bridge.
package blssb_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned UART_BAUD = 57600;
  localparam int unsigned UART_DIV = CLK_HZ / UART_BAUD;
  localparam int unsigned SPI_HALF = 4;
  localparam logic [7:0] IC_WRITE_ADDR = 8'h01;
  localparam logic [7:0] IC_READ_ADDR = 8'h02;
  localparam logic [7:0] IC_OPC_ONLY = 8'h04;
  localparam logic [7:0] IC_OPC_ADDR = 8'h08;
  localparam logic [7:0] IC_OPC_READ = 8'h10;
  localparam logic [7:0] IC_OPC_WRITE = 8'h20;
  localparam logic [7:0] FLASH_READ_OPC = 8'h03;
  localparam logic [23:0] HDR_ADDR = 24'h000000;
  localparam int unsigned HDR_BYTES = 6;
  localparam int unsigned SRAM_AW = 17;
  localparam logic [16:0] SRAM_TOP = 17'h1FFFF;
  localparam logic [16:0] SRAM_BASE = 17'h00000;
  localparam logic [11:0] PAGE4K_MASK = 12'hFFF;
  localparam int unsigned CFG_WDG_BIT = 1;
  localparam int unsigned CFG_RELOAD_BIT = 2;
  typedef enum logic [4:0] {
    BL_IDLE, BL_HDR_CMD, BL_HDR_RD, BL_COPY_CMD, BL_COPY_RD, BL_ENC, BL_DONE,
    BL_P_LOADER_INSTRUCTION_CODE, BL_P_BC0, BL_P_BC1, BL_P_OPC, BL_P_AD, BL_P_WR, BL_P_RD, BL_P_TX, BL_P_END
  } blssb_state_e;
endpackage

/* blssb_spi_byte.sv */
// One byte SPI mode 0 shifter with an enable pulse divider.
`timescale 1ns/1ps
`default_nettype none
module blssb_spi_byte (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_done,
  output logic [7:0] o_data
);
  import blssb_pkg::*;
  typedef struct packed {
    logic busy;
    logic [7:0] div;
    logic [3:0] bits;
    logic sclk;
    logic [7:0] sh;
    logic [7:0] rx;
    logic done;
  } blssb_spi_s;
  blssb_spi_s r;
  blssb_spi_s next_r;
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (!r.busy) begin
      if (i_start) begin
        next_r.busy = 1'b1;
        next_r.sh = i_data;
        next_r.bits = 4'h0;
        next_r.div = 8'h00;
      end
    end else if (r.div == 8'(SPI_HALF - 1)) begin
      next_r.div = 8'h00;
      // Mode 0: sample on the rising edge, shift on the falling edge.
      if (!r.sclk) begin
        next_r.sclk = 1'b1;
        next_r.rx = {r.rx[6:0], i_miso};
      end else begin
        next_r.sclk = 1'b0;
        next_r.sh = {r.sh[6:0], 1'b0};
        next_r.bits = r.bits + 4'h1;
        if (r.bits == 4'h7) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
      end
    end else begin
      next_r.div = r.div + 8'h01;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign o_sclk = r.sclk;
  assign o_mosi = r.sh[7];
  assign o_done = r.done;
  assign o_data = r.rx;
endmodule
`default_nettype wire

/* blssb_top.sv */
// Boot loader: flash to SRAM copy in execution mode, UART to SPI bridge in programming mode.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01: Programming strap sampled after reset; low programs, high executes.
// R02: Encryption allowed only while the secure strap is high.
// R03: During boot the loader owns UART0 and the four flash pins.
// R04: After boot the shared pins pass to software unchanged.
// R05: Programming host link runs 57600 baud, 8 data, 1 stop, no parity.
// R06: Host command is code, count, then opcode, address and data.
// R07: Instruction code selects which fields follow the opcode.
// R08: Count field is bytes minus one; unused for non data codes.
// R09: With 264 byte pages the count field is two bytes.
// R10: Address is 24 bits, most significant byte first.
// R11: Programming mode forwards each command's SPI part to the flash.
// R12: Execution mode copies firmware into SRAM from address zero.
// R13: Supports 128 KB SRAM and flash up to 16 Mbit.
// R14: Data address A maps to SRAM top minus A.
// R15: Six lowest flash bytes give start and end; copy exactly that range.
// R16: Processor runs only after the copy has finished.
// R17: Software or watchdog reload request repeats the copy.
// R18: Auto encryption needs all straps, serial number, addresses and 4 KB start.
// R19: First run encrypts image padded to 4 KB, then executes.
// R20: An already encrypted image skips encryption.
// R21: No external indication while encryption runs.
// R22: Flash read uses SPI mode 0 and opcode 03.
// R23: Loader runs after power on, reset and forced reload bit.
// R24: Watchdog timeout reloads only with the watchdog enable bit set.
// R25: Select held low across the whole command, raised after last byte.
// R26: Read bytes return to the host in order.
module blssb_top (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PROGRAM_MODE_STRAP_N,
  input wire logic I_SECURE_BOOT_STRAP,
  input wire logic I_DEBUG_STRAP,
  input wire logic I_SERIAL_NUMBER_VALID,
  input wire logic I_IMAGE_ENCRYPTED,
  input wire logic I_PAGE_264,
  input wire logic [2:0] I_LOADER_CONFIG_REGISTER,
  input wire logic I_CONFIG_WRITE,
  input wire logic I_WATCHDOG_TIMEOUT,
  input wire logic I_ENCRYPT_DONE,
  input wire logic [16:0] I_CPU_DATA_ADDR,
  input wire logic I_UART0_RECEIVE,
  output logic O_UART0_TRANSMIT,
  input wire logic I_SW_UART0_TRANSMIT,
  output logic O_SW_UART0_RECEIVE,
  input wire logic I_FLASH_SERIAL_IN,
  output logic O_FLASH_SELECT_N,
  output logic O_FLASH_SERIAL_CLOCK,
  output logic O_FLASH_SERIAL_OUT,
  input wire logic I_SW_FLASH_SELECT_N,
  input wire logic I_SW_FLASH_SERIAL_CLOCK,
  input wire logic I_SW_FLASH_SERIAL_OUT,
  output logic O_SW_FLASH_SERIAL_IN,
  output logic O_SRAM_WRITE,
  output logic [16:0] O_SRAM_ADDR,
  output logic [7:0] O_SRAM_DATA,
  output logic [16:0] O_CPU_SRAM_ADDR,
  output logic O_ENCRYPT_START,
  output logic O_CPU_RUN,
  output logic O_BOOT_ACTIVE
);
  import blssb_pkg::*;
  // ************************************************************
  // Function and state.
  // ************************************************************
  function automatic logic has_addr(input logic [7:0] ic);
    has_addr = (ic == IC_WRITE_ADDR) || (ic == IC_READ_ADDR) || (ic == IC_OPC_ADDR);
  endfunction
  typedef struct packed {
    blssb_state_e st;
    logic [2:0] sync_rx;
    logic [1:0] sync_miso;
    logic [2:0] sync_program_mode_strap_n;
    logic [1:0] sync_sec;
    logic strap_taken;
    logic program_mode_strap_n_mode;
    logic active;
    logic cpu_run;
    logic ss_n;
    logic [23:0] faddr;
    logic [23:0] fend;
    // Kept apart from faddr, which walks past the end during the copy.
    logic [23:0] fstart;
    logic [47:0] hdr;
    logic [2:0] cnt;
    logic [7:0] loader_instruction_code;
    logic [15:0] bc;
    logic [15:0] left;
    logic [16:0] sram_addr;
    logic sram_wr;
    logic [7:0] sram_data;
    logic enc_start;
    logic spi_go;
    logic [7:0] spi_tx;
    logic [15:0] rx_div;
    logic [3:0] rx_bit;
    logic rx_busy;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic [15:0] tx_div;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic reload_req;
  } blssb_state_s;
  blssb_state_s r;
  blssb_state_s next_r;
  logic spi_done;
  logic spi_sclk;
  logic spi_mosi;
  logic [7:0] spi_rx;
  blssb_spi_byte u_spi (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_start(r.spi_go),
    .i_data(r.spi_tx),
    .i_miso(r.sync_miso[1]),
    .o_sclk(spi_sclk),
    .o_mosi(spi_mosi),
    .o_done(spi_done),
    .o_data(spi_rx)
  );
  logic enc_ok;
  logic reload_hit;
  assign enc_ok = r.sync_sec[1] && !I_DEBUG_STRAP && !r.program_mode_strap_n_mode //R02 R18
    && I_SERIAL_NUMBER_VALID && (r.fend > r.fstart) && !I_IMAGE_ENCRYPTED //R20
    && ((r.fstart[11:0] & PAGE4K_MASK) == 12'h000);
  assign reload_hit = I_CONFIG_WRITE && I_LOADER_CONFIG_REGISTER[CFG_RELOAD_BIT] //R17 R23
    || I_WATCHDOG_TIMEOUT && I_LOADER_CONFIG_REGISTER[CFG_WDG_BIT]; //R24
  // ************************************************************
  // Next state.
  // ************************************************************
  always_comb begin
    next_r = r;
    next_r.sync_rx = {r.sync_rx[1:0], I_UART0_RECEIVE};
    next_r.sync_miso = {r.sync_miso[0], I_FLASH_SERIAL_IN};
    next_r.sync_program_mode_strap_n = {r.sync_program_mode_strap_n[1:0], I_PROGRAM_MODE_STRAP_N};
    next_r.sync_sec = {r.sync_sec[0], I_SECURE_BOOT_STRAP};
    next_r.spi_go = 1'b0;
    next_r.sram_wr = 1'b0;
    next_r.enc_start = 1'b0;
    next_r.rx_valid = 1'b0;
    if (reload_hit && r.cpu_run) begin
      next_r.reload_req = 1'b1;
    end
    // UART receiver, 8N1, sampled mid bit.
    if (!r.rx_busy) begin
      if (!r.sync_rx[2] && r.active && r.program_mode_strap_n_mode) begin //R05
        next_r.rx_busy = 1'b1;
        next_r.rx_div = 16'(UART_DIV / 2);
        next_r.rx_bit = 4'h0;
      end
    end else if (r.rx_div == 16'h0000) begin
      next_r.rx_div = 16'(UART_DIV - 1);
      next_r.rx_bit = r.rx_bit + 4'h1;
      if (r.rx_bit >= 4'h1 && r.rx_bit <= 4'h8) begin
        next_r.rx_sh = {r.sync_rx[2], r.rx_sh[7:1]};
      end
      if (r.rx_bit == 4'h9) begin
        next_r.rx_busy = 1'b0;
        next_r.rx_valid = r.sync_rx[2];
      end
    end else begin
      next_r.rx_div = r.rx_div - 16'h0001;
    end
    // UART transmitter shifts in idle ones behind the frame and holds when empty.
    if (r.tx_bit != 4'h0) begin
      if (r.tx_div == 16'h0000) begin
        next_r.tx_div = 16'(UART_DIV - 1);
        next_r.tx_sh = {1'b1, r.tx_sh[9:1]};
        next_r.tx_bit = r.tx_bit - 4'h1;
      end else begin
        next_r.tx_div = r.tx_div - 16'h0001;
      end
    end
    case (r.st)
      BL_IDLE: begin
        if (!r.strap_taken && (r.sync_program_mode_strap_n[2:1] == 2'b11 || r.sync_program_mode_strap_n[2:1] == 2'b00)) begin
          next_r.strap_taken = 1'b1;
          next_r.program_mode_strap_n_mode = !r.sync_program_mode_strap_n[2]; //R01
          next_r.active = 1'b1;
          next_r.ss_n = 1'b0;
          next_r.cnt = 3'h0;
          if (r.sync_program_mode_strap_n[2]) begin
            next_r.spi_go = 1'b1;
            next_r.spi_tx = FLASH_READ_OPC; //R22
            next_r.faddr = HDR_ADDR;
            next_r.st = BL_HDR_CMD;
          end else begin
            next_r.ss_n = 1'b1;
            next_r.st = BL_P_LOADER_INSTRUCTION_CODE;
          end
        end
      end
      BL_HDR_CMD: begin
        if (spi_done) begin
          next_r.cnt = r.cnt + 3'h1;
          next_r.spi_go = 1'b1;
          next_r.spi_tx = (r.cnt == 3'h3) ? 8'h00 : 8'h00;
          if (r.cnt == 3'h3) begin
            next_r.cnt = 3'h0;
            next_r.st = BL_HDR_RD;
          end
        end
      end
      BL_HDR_RD: begin
        if (spi_done) begin
          next_r.hdr = {r.hdr[39:0], spi_rx}; //R15
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt == 3'(HDR_BYTES - 1)) begin
            next_r.faddr = r.hdr[39:16];
            next_r.fstart = r.hdr[39:16];
            next_r.fend = {r.hdr[15:0], spi_rx};
            next_r.ss_n = 1'b1;
            next_r.cnt = 3'h0;
            next_r.st = BL_COPY_CMD;
          end else begin
            next_r.spi_go = 1'b1;
          end
        end
      end
      BL_COPY_CMD: begin
        if (r.ss_n) begin
          next_r.ss_n = 1'b0;
          next_r.spi_go = 1'b1;
          next_r.spi_tx = FLASH_READ_OPC; //R22
          next_r.sram_addr = SRAM_BASE; //R12
        end else if (spi_done) begin
          next_r.cnt = r.cnt + 3'h1;
          next_r.spi_go = 1'b1;
          next_r.spi_tx = (r.cnt == 3'h0) ? r.faddr[23:16] :
                          (r.cnt == 3'h1) ? r.faddr[15:8] : r.faddr[7:0];
          if (r.cnt == 3'h3) begin
            next_r.spi_tx = 8'h00;
            next_r.st = BL_COPY_RD;
          end
        end
      end
      BL_COPY_RD: begin
        if (spi_done) begin
          next_r.sram_wr = 1'b1;
          next_r.sram_data = spi_rx;
          next_r.sram_addr = r.sram_addr;
          next_r.faddr = r.faddr + 24'h000001;
          if (r.faddr >= r.fend || r.sram_addr == SRAM_TOP) begin //R13 R15
            next_r.ss_n = 1'b1;
            next_r.st = BL_ENC;
          end else begin
            next_r.spi_go = 1'b1;
          end
        end else if (r.sram_wr) begin
          next_r.sram_addr = r.sram_addr + 17'h00001;
        end
      end
      BL_ENC: begin
        // Encryption runs externally and silently; the select stays high throughout.
        if (enc_ok && r.sync_sec[1] && !r.enc_start && !I_ENCRYPT_DONE) begin //R19 R21
          next_r.enc_start = 1'b1;
        end
        if (!enc_ok || I_ENCRYPT_DONE) begin
          next_r.st = BL_DONE;
        end
      end
      BL_DONE: begin
        next_r.active = 1'b0; //R04
        next_r.cpu_run = 1'b1; //R16
        if (r.reload_req) begin
          next_r.reload_req = 1'b0;
          next_r.cpu_run = 1'b0;
          next_r.strap_taken = 1'b0;
          next_r.st = BL_IDLE;
        end
      end
      BL_P_LOADER_INSTRUCTION_CODE: begin
        if (r.rx_valid) begin
          next_r.loader_instruction_code = r.rx_sh; //R06
          next_r.st = BL_P_BC0;
        end
      end
      BL_P_BC0: begin
        if (r.rx_valid) begin
          next_r.bc = {8'h00, r.rx_sh};
          next_r.st = I_PAGE_264 ? BL_P_BC1 : BL_P_OPC; //R09
        end
      end
      BL_P_BC1: begin
        if (r.rx_valid) begin
          next_r.bc = {r.bc[7:0], r.rx_sh};
          next_r.st = BL_P_OPC;
        end
      end
      BL_P_OPC: begin
        if (r.rx_valid) begin
          next_r.ss_n = 1'b0; //R11 R25
          next_r.spi_go = 1'b1;
          next_r.spi_tx = r.rx_sh;
          next_r.left = r.bc; //R08
          next_r.cnt = 3'h0;
          next_r.st = has_addr(r.loader_instruction_code) ? BL_P_AD : //R07
                      (r.loader_instruction_code == IC_OPC_WRITE) ? BL_P_WR :
                      (r.loader_instruction_code == IC_OPC_READ) ? BL_P_RD : BL_P_END;
        end
      end
      BL_P_AD: begin
        if (r.rx_valid) begin //R10
          next_r.spi_go = 1'b1;
          next_r.spi_tx = r.rx_sh;
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt == 3'h2) begin
            next_r.st = (r.loader_instruction_code == IC_WRITE_ADDR) ? BL_P_WR :
                        (r.loader_instruction_code == IC_READ_ADDR) ? BL_P_RD : BL_P_END;
          end
        end
      end
      BL_P_WR: begin
        if (r.rx_valid) begin
          next_r.spi_go = 1'b1;
          next_r.spi_tx = r.rx_sh;
          next_r.left = r.left - 16'h0001;
          if (r.left == 16'h0000) begin
            next_r.st = BL_P_END;
          end
        end
      end
      BL_P_RD: begin
        if (spi_done || r.spi_go) begin
          next_r.spi_go = spi_done;
          next_r.spi_tx = 8'h00;
          if (spi_done && r.spi_go == 1'b0 && r.cnt == 3'h7) begin
            next_r.tx_sh = {1'b1, spi_rx, 1'b0}; //R26
            next_r.tx_bit = 4'hA;
            next_r.tx_div = 16'(UART_DIV - 1);
            next_r.spi_go = 1'b0;
            next_r.st = BL_P_TX;
          end
          next_r.cnt = spi_done ? 3'h7 : r.cnt;
        end
      end
      BL_P_TX: begin
        if (r.tx_bit == 4'h0) begin
          next_r.left = r.left - 16'h0001;
          if (r.left == 16'h0000) begin
            next_r.ss_n = 1'b1; //R25
            next_r.st = BL_P_LOADER_INSTRUCTION_CODE;
          end else begin
            next_r.spi_go = 1'b1;
            next_r.st = BL_P_RD;
          end
        end
      end
      BL_P_END: begin
        if (spi_done) begin
          next_r.ss_n = 1'b1; //R25
          next_r.st = BL_P_LOADER_INSTRUCTION_CODE;
        end
      end
      default: begin
        next_r.st = BL_IDLE;
      end
    endcase
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      r <= '0;
      r.ss_n <= 1'b1;
      r.tx_sh <= 10'h3FF;
      r.sync_rx <= 3'h7;
      r.sync_program_mode_strap_n <= 3'h2;
    end else begin
      r <= next_r;
    end
  end
  // ************************************************************
  // Pin switch and outputs.
  // ************************************************************
  assign O_FLASH_SELECT_N = r.active ? r.ss_n : I_SW_FLASH_SELECT_N; //R03 R04
  assign O_FLASH_SERIAL_CLOCK = r.active ? spi_sclk : I_SW_FLASH_SERIAL_CLOCK; //R22
  assign O_FLASH_SERIAL_OUT = r.active ? spi_mosi : I_SW_FLASH_SERIAL_OUT;
  assign O_UART0_TRANSMIT = r.active ? r.tx_sh[0] : I_SW_UART0_TRANSMIT; //R03
  assign O_SW_UART0_RECEIVE = r.active ? 1'b1 : I_UART0_RECEIVE;
  assign O_SW_FLASH_SERIAL_IN = r.active ? 1'b1 : I_FLASH_SERIAL_IN;
  assign O_CPU_SRAM_ADDR = SRAM_TOP - I_CPU_DATA_ADDR; //R14
  assign O_SRAM_WRITE = r.sram_wr;
  assign O_SRAM_ADDR = r.sram_addr;
  assign O_SRAM_DATA = r.sram_data;
  assign O_ENCRYPT_START = r.enc_start;
  assign O_CPU_RUN = r.cpu_run;
  assign O_BOOT_ACTIVE = r.active;
  AST_RUN_AFTER_COPY: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R16
    O_CPU_RUN |-> !O_BOOT_ACTIVE) else $error("Processor runs while loader active.");
  AST_SELECT_IDLE: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R25
    (r.st == BL_P_LOADER_INSTRUCTION_CODE && r.active) |-> O_FLASH_SELECT_N) else $error("Select low between commands.");
  AST_CLK_IDLE_LOW: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R22
    (r.active && O_FLASH_SELECT_N) |-> !O_FLASH_SERIAL_CLOCK) else $error("Clock not idle low.");
  AST_ADDR_XLATE: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R14
    O_CPU_SRAM_ADDR + I_CPU_DATA_ADDR == SRAM_TOP) else $error("Bad address translation.");
  AST_ENC_GATED: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R02
    O_ENCRYPT_START |-> $past(I_SECURE_BOOT_STRAP) && !r.program_mode_strap_n_mode) else $error("Bad encrypt start.");
  AST_RELEASE: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R04
    !O_BOOT_ACTIVE |-> O_FLASH_SELECT_N == I_SW_FLASH_SELECT_N) else $error("Pins not released.");
  AST_COPY_START: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R12
    $rose(r.st == BL_COPY_RD) |-> O_SRAM_ADDR == SRAM_BASE) else $error("Copy not at zero.");
  AST_NO_TX_EXEC: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) //R21
    (r.st == BL_ENC) |-> O_UART0_TRANSMIT) else $error("Signal during encryption.");
endmodule
`default_nettype wire

/* blssb_top_test.sv */
// Self-checking bench for the boot loader serial SPI bridge.
`timescale 1ns/1ps
`default_nettype none
module blssb_top_test;
  import blssb_pkg::*;
  logic clk, rst, strap_n, secure, debug, sn_ok, img_enc, cfg_wr, wdg, enc_done, act_q;
  logic [2:0] cfg;
  logic [16:0] cpu_addr, sram_addr, cpu_sram_addr;
  logic rx, sw_tx, sw_sel_n, sw_sclk, sw_mosi, miso;
  logic tx, sw_rx, sel_n, sclk, mosi, sw_miso, sram_wr, enc_start, run, active;
  logic [7:0] sram_data;
  int n_fail, checked, n_boot, n_enc, n_bad, cyc;
  logic [16:0] wr_addr [$];
  logic [7:0] wr_data [$];
  blssb_top blssb_top_i (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PROGRAM_MODE_STRAP_N(strap_n),
    .I_SECURE_BOOT_STRAP(secure), .I_DEBUG_STRAP(debug), .I_SERIAL_NUMBER_VALID(sn_ok),
    .I_IMAGE_ENCRYPTED(img_enc), .I_PAGE_264(1'b0), .I_LOADER_CONFIG_REGISTER(cfg),
    .I_CONFIG_WRITE(cfg_wr), .I_WATCHDOG_TIMEOUT(wdg), .I_ENCRYPT_DONE(enc_done),
    .I_CPU_DATA_ADDR(cpu_addr), .I_UART0_RECEIVE(rx), .O_UART0_TRANSMIT(tx),
    .I_SW_UART0_TRANSMIT(sw_tx), .O_SW_UART0_RECEIVE(sw_rx), .I_FLASH_SERIAL_IN(miso),
    .O_FLASH_SELECT_N(sel_n), .O_FLASH_SERIAL_CLOCK(sclk), .O_FLASH_SERIAL_OUT(mosi),
    .I_SW_FLASH_SELECT_N(sw_sel_n), .I_SW_FLASH_SERIAL_CLOCK(sw_sclk),
    .I_SW_FLASH_SERIAL_OUT(sw_mosi), .O_SW_FLASH_SERIAL_IN(sw_miso),
    .O_SRAM_WRITE(sram_wr), .O_SRAM_ADDR(sram_addr), .O_SRAM_DATA(sram_data),
    .O_CPU_SRAM_ADDR(cpu_sram_addr), .O_ENCRYPT_START(enc_start), .O_CPU_RUN(run),
    .O_BOOT_ACTIVE(active)
  );
  blssb_flash_model flash_i (.i_sel_n(sel_n), .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso));
  // ****************************************
  // Clock, monitors and shared tasks.
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    act_q <= active;
    cyc <= cyc + 1;
    n_boot <= n_boot + int'(active && !act_q);
    n_enc <= n_enc + int'(enc_start);
    // Loader owns the idle-high transmit line and a quiet flash clock while booting.
    n_bad <= n_bad + int'(sram_wr && run) + int'(active && strap_n && (!tx || (sel_n && sclk)));
    if (sram_wr) begin
      wr_addr.push_back(sram_addr);
      wr_data.push_back(sram_data);
    end
    enc_done <= (enc_done | enc_start) & active;
    if (cyc == 99000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input int lim, ref logic sig, input logic val);
    for (int i = 0; i < lim && sig !== val; i++) @(posedge clk);
    chk(24'(sig), 24'(val));
  endtask
  task automatic clear_logs;
    // Step past the monitor's updates of this edge so that the clears stick.
    #1;
    wr_addr.delete();
    wr_data.delete();
    flash_i.ops.delete();
    flash_i.addrs.delete();
    flash_i.lens.delete();
    n_enc = 0;
    n_bad = 0;
    n_boot = 0;
    @(posedge clk);
  endtask
  task automatic kick(input logic [2:0] c, input logic w);
    @(posedge clk);
    cfg <= c;
    cfg_wr <= ~w;
    wdg <= w;
    @(posedge clk);
    cfg_wr <= 1'b0;
    wdg <= 1'b0;
  endtask
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rx <= f[k];
      repeat (UART_DIV) @(posedge clk);
    end
  endtask
  task automatic uart_recv(output logic [7:0] b);
    wait_for(70000, tx, 1'b0);
    repeat (UART_DIV / 2) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (UART_DIV) @(posedge clk);
      b[k] = tx;
    end
    repeat (UART_DIV) @(posedge clk);
    chk(24'(tx), 24'h1);
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic boot_check(input int exp_enc);
    wait_for(50, active, 1'b1);
    wait_for(20000, run, 1'b1);
    wait_for(10, active, 1'b0);
    chk(24'(wr_addr.size()), 24'd4);
    for (int i = 0; i < wr_addr.size(); i++) begin
      chk(24'(wr_addr[i]), 24'(SRAM_BASE) + 24'(i));
      chk(24'(wr_data[i]), 24'(flash_i.mem[4096 + i]));
    end
    chk(24'(flash_i.ops[0]), 24'(FLASH_READ_OPC));
    chk(flash_i.addrs[0], HDR_ADDR);
    chk(flash_i.addrs[1], 24'h001000);
    chk(24'(n_enc), 24'(exp_enc));
    chk(24'(n_bad), 24'h0);
  endtask
  task automatic pins_released;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      sw_sel_n <= i[0];
      sw_sclk <= ~i[0];
      sw_mosi <= i[0];
      sw_tx <= i[0];
      rx <= i[0];
      @(posedge clk);
      #1;
      chk({19'h0, sel_n, sclk, mosi, tx, sw_rx}, {19'h0, i[0], ~i[0], i[0], i[0], i[0]});
      chk(24'(sw_miso), 24'(miso));
    end
  endtask
  task automatic program_mode_strap_n_cmds;
    logic [7:0] b;
    logic [7:0] rd_cmd [6] = '{IC_READ_ADDR, 8'h00, FLASH_READ_OPC, 8'h00, 8'h10, 8'h01};
    logic [7:0] op_cmd [3] = '{IC_OPC_ONLY, 8'h55, 8'h06};
    clear_logs();
    fork
      foreach (rd_cmd[k]) uart_send(rd_cmd[k]);
      uart_recv(b);
    join
    for (int i = 0; i < 2000 && flash_i.lens.size() < 1; i++) @(posedge clk);
    chk(24'(b), 24'(flash_i.mem[13'h1001]));
    chk(24'(flash_i.ops[0]), 24'(FLASH_READ_OPC));
    chk(flash_i.addrs[0], 24'h001001);
    chk(24'(flash_i.lens[0]), 24'd5);
    foreach (op_cmd[k]) uart_send(op_cmd[k]);
    for (int i = 0; i < 2000 && flash_i.lens.size() < 2; i++) @(posedge clk);
    chk(24'(flash_i.ops[1]), 24'h06);
    chk(24'(flash_i.lens[1]), 24'd1);
    chk({23'h0, run}, 24'(wr_addr.size()));
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst, strap_n, rx, sw_sel_n} <= 4'hF;
    {secure, debug, sn_ok, img_enc, cfg_wr, wdg, enc_done, sw_tx, sw_sclk, sw_mosi} <= 10'h000;
    cfg <= 3'h0;
    cpu_addr <= 17'h00000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    boot_check(0);
    cpu_addr <= 17'h00123;
    @(posedge clk);
    #1;
    chk(24'(cpu_sram_addr), 24'(SRAM_TOP - 17'h00123));
    pins_released();
    sw_tx <= 1'b0;
    secure <= 1'b1;
    sn_ok <= 1'b1;
    clear_logs();
    kick(3'b100, 1'b0);
    boot_check(1);
    img_enc <= 1'b1;
    clear_logs();
    kick(3'b000, 1'b0);
    kick(3'b000, 1'b1);
    kick(3'b010, 1'b0);
    repeat (100) @(posedge clk);
    chk(24'(n_boot), 24'h0);
    kick(3'b010, 1'b1);
    boot_check(0);
    img_enc <= 1'b0;
    debug <= 1'b1;
    clear_logs();
    kick(3'b100, 1'b0);
    boot_check(0);
    rst <= 1'b1;
    strap_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    program_mode_strap_n_cmds();
    tally_and_finish();
  end
endmodule
`default_nettype wire
